// ===== hw/arl_top.v
// Purpose: Abort/reset push button decoding, board hard reset and status LEDs.
// Assumes: All pin inputs are asynchronous; register port on CLK.
// Notes:   Long counts are parameters so simulation can shorten them.
`timescale 1ns/10ps
`default_nettype none
`include "arl_map.vh"

// What this block does
// - Button released before five seconds raises abort interrupt, no board reset.
// - Button held longer than five seconds issues a board hard reset.
// - Hard reset drives processor, PCI, PHY, serial, flash and PLD resets.
// - As system controller, hard reset also resets backplane and bridge.
// - Fail LED on at power-on and every reset until software clears it.
// - Each of three user LEDs lit exactly while its control bit is set.
// - Power-fail LED lit whenever supply failure is signalled.
// - Network activity LEDs blink with traffic rate, off without activity.
// - Storage LED 0 shows either port in legacy mode, port 0 in dual mode.
// - Storage LED 1 dark in legacy mode, shows port 1 in dual mode.
// - Processor-ready LED follows shared ready/trigger pin of the processor outside hard reset, dark while hard reset is held.
// - Link-quality LEDs: off, slow blink, fast blink, steady on by SNR.
module arl_top #(
	parameter integer LONG_PRESS_CYC = `ARL_LONG_PRESS_MS * (`ARL_CLK_HZ / 1000),
	parameter integer DEBOUNCE_CYC   = `ARL_DEBOUNCE_MS * (`ARL_CLK_HZ / 1000),
	parameter integer HRESET_CYC     = `ARL_HRESET_MS * (`ARL_CLK_HZ / 1000),
	parameter integer SLOW_HALF_CYC  = `ARL_SLOW_HALF_MS * (`ARL_CLK_HZ / 1000),
	parameter integer FAST_HALF_CYC  = `ARL_FAST_HALF_MS * (`ARL_CLK_HZ / 1000),
	parameter integer ACT_WINDOW_CYC = `ARL_ACT_WINDOW_MS * (`ARL_CLK_HZ / 1000)
) (
	input  wire        CLK,
	input  wire        RESETN,
	input  wire [7:0]  ADDR,
	input  wire [31:0] WDATA,
	input  wire        WR,
	input  wire        RD,
	output reg  [31:0] RDATA,
	input  wire        ABORT_RESET_BUTTON_N,
	input  wire        SYS_CONTROLLER,
	input  wire        DUAL_PORT_STORAGE_MODE,
	input  wire        PSU_FAIL_N,
	input  wire        STORAGE0_ACT,
	input  wire        STORAGE1_ACT,
	input  wire        PROCESSOR_TRIGGER_OUTPUT,
	input  wire [2:0]  NET_ACT,
	input  wire [1:0]  LINK0_SNR,
	input  wire [1:0]  LINK1_SNR,
	output reg         ABORT_IRQ_N,
	output reg         CPU_RESET_N,
	output reg         PCI_RESET_N,
	output reg         PHY_RESET_N,
	output reg         SERIAL_RESET_N,
	output reg         FLASH_RESET_N,
	output reg         PLD_RESET_N,
	output reg         BACKPLANE_RESET_N,
	output reg         BRIDGE_RESET_N,
	output reg         FAIL_LED,
	output reg  [2:0]  USER_LED,
	output reg         POWER_FAIL_LED,
	output reg         STORAGE_LED0,
	output reg         STORAGE_LED1,
	output reg         CPU_READY_LED,
	output wire [2:0]  NET_ACT_LED,
	output wire [1:0]  LINK_QUALITY_LED
);
	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_PRESS = 2'h1;
	localparam [1:0] ST_WAIT  = 2'h2;

	reg  [`ARL_SYNC_W-1:0] sync1;
	reg  [`ARL_SYNC_W-1:0] sync2;
	reg  [31:0]            deb_cnt;
	reg                    btn;
	reg  [1:0]             state;
	reg  [31:0]            press_cnt;
	reg                    hr_active;
	reg  [31:0]            hr_cnt;
	reg                    fail;
	reg                    abort_pend;
	reg  [2:0]             user_ctrl;
	reg  [1:0]             cap_cnt;
	reg                    dual_mode;
	reg  [2:0]             act_prev;
	reg  [31:0]            win_cnt;
	reg  [23:0]            evt_cnt;
	reg  [5:0]             act_mode;
	wire                   btn_raw;
	wire                   sys_ctrl;
	wire                   psu_fail;
	wire [2:0]             net_act;
	wire [1:0]             snr0;
	wire [1:0]             snr1;
	wire                   short_rel;
	wire                   long_hit;
	wire                   wr_status;
	wire                   win_end;
	wire [9:0]             blink_mode;

	// Bit order of the synchroniser bank, low to high
	assign btn_raw  = ~sync2[0];
	assign sys_ctrl = sync2[1];
	assign psu_fail = ~sync2[3];
	assign net_act  = sync2[9:7];
	assign snr0     = sync2[11:10];
	assign snr1     = sync2[13:12];

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			sync1 <= `ARL_SYNC_RST;
			sync2 <= `ARL_SYNC_RST;
		end else begin
			sync1 <= {LINK1_SNR, LINK0_SNR, NET_ACT, PROCESSOR_TRIGGER_OUTPUT,
				STORAGE1_ACT, STORAGE0_ACT, PSU_FAIL_N, DUAL_PORT_STORAGE_MODE,
				SYS_CONTROLLER, ABORT_RESET_BUTTON_N};
			sync2 <= sync1;
		end
	end

	// Button must disagree with its filtered value for the whole window
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			deb_cnt <= 32'h0;
			btn <= 1'b0;
		end else if (btn_raw != btn) begin
			if (deb_cnt >= DEBOUNCE_CYC - 1) begin
				deb_cnt <= 32'h0;
				btn <= btn_raw;
			end else begin
				deb_cnt <= deb_cnt + 32'h1;
			end
		end else begin
			deb_cnt <= 32'h0;
		end
	end

	assign short_rel = (state == ST_PRESS) && !btn;
	assign long_hit  = (state == ST_PRESS) && btn && (press_cnt >= LONG_PRESS_CYC);

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state <= ST_IDLE;
			press_cnt <= 32'h0;
		end else begin
			case (state)
				ST_IDLE: begin
					press_cnt <= 32'h0;
					if (btn)
						state <= ST_PRESS;
				end
				ST_PRESS: begin
					if (!btn)
						state <= ST_IDLE;
					else if (long_hit)
						state <= ST_WAIT;
					else
						press_cnt <= press_cnt + 32'h1;
				end
				ST_WAIT: begin
					// A long press never turns into an abort on release
					if (!btn)
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Resets are held from power-on until the hold time has run out
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			hr_active <= 1'b1;
			hr_cnt <= 32'h0;
		end else if (long_hit) begin
			hr_active <= 1'b1;
			hr_cnt <= 32'h0;
		end else if (hr_active) begin
			if (hr_cnt >= HRESET_CYC - 1)
				hr_active <= 1'b0;
			else
				hr_cnt <= hr_cnt + 32'h1;
		end
	end

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			CPU_RESET_N <= 1'b0;
			PCI_RESET_N <= 1'b0;
			PHY_RESET_N <= 1'b0;
			SERIAL_RESET_N <= 1'b0;
			FLASH_RESET_N <= 1'b0;
			PLD_RESET_N <= 1'b0;
			BACKPLANE_RESET_N <= 1'b1;
			BRIDGE_RESET_N <= 1'b1;
		end else begin
			CPU_RESET_N <= ~hr_active;
			PCI_RESET_N <= ~hr_active;
			PHY_RESET_N <= ~hr_active;
			SERIAL_RESET_N <= ~hr_active;
			FLASH_RESET_N <= ~hr_active;
			PLD_RESET_N <= ~hr_active;
			BACKPLANE_RESET_N <= ~(hr_active & sys_ctrl);
			BRIDGE_RESET_N <= ~(hr_active & sys_ctrl);
		end
	end

	assign wr_status = WR && (ADDR == `ARL_REG_STATUS);

	// A new event in the clearing cycle keeps its flag set
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			fail <= 1'b1;
			abort_pend <= 1'b0;
			user_ctrl <= `ARL_LED_CTRL_RST;
		end else begin
			if (long_hit)
				fail <= 1'b1;
			else if (wr_status && WDATA[`ARL_ST_FAIL])
				fail <= 1'b0;
			if (short_rel)
				abort_pend <= 1'b1;
			else if (wr_status && WDATA[`ARL_ST_ABORT])
				abort_pend <= 1'b0;
			if (WR && (ADDR == `ARL_REG_LED_CTRL))
				user_ctrl <= WDATA[`ARL_USER_LED_LSB+2:`ARL_USER_LED_LSB];
		end
	end

	// Storage mode strap is taken once the synchroniser holds real pin data
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cap_cnt <= 2'h0;
			dual_mode <= 1'b0;
		end else if (cap_cnt != 2'h3) begin
			cap_cnt <= cap_cnt + 2'h1;
			if (cap_cnt == 2'h2)
				dual_mode <= sync2[2];
		end
	end

	// Count activity edges per window; more edges give a faster blink
	assign win_end = (win_cnt >= ACT_WINDOW_CYC - 1);

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			win_cnt <= 32'h0;
		else if (win_end)
			win_cnt <= 32'h0;
		else
			win_cnt <= win_cnt + 32'h1;
	end

	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_act
			wire       evt;
			wire [7:0] cnt;
			assign evt = net_act[i] & ~act_prev[i];
			assign cnt = evt_cnt[8*i+7:8*i];
			always @(posedge CLK or negedge RESETN) begin
				if (!RESETN) begin
					act_prev[i] <= 1'b0;
					evt_cnt[8*i+7:8*i] <= 8'h00;
					act_mode[2*i+1:2*i] <= `ARL_BLINK_OFF;
				end else begin
					act_prev[i] <= net_act[i];
					if (win_end) begin
						evt_cnt[8*i+7:8*i] <= {7'h00, evt};
						if (cnt == 8'h00)
							act_mode[2*i+1:2*i] <= `ARL_BLINK_OFF;
						else if (cnt < `ARL_ACT_BUSY_EVENTS)
							act_mode[2*i+1:2*i] <= `ARL_BLINK_SLOW;
						else
							act_mode[2*i+1:2*i] <= `ARL_BLINK_FAST;
					end else if (evt && cnt != 8'hff) begin
						evt_cnt[8*i+7:8*i] <= cnt + 8'h01;
					end
				end
			end
		end
	endgenerate

	// Both link quality LEDs share one encoding of the PHY SNR level
	assign blink_mode = {snr1, snr0, act_mode};

	generate
		for (i = 0; i < 5; i = i + 1) begin : g_led
			wire led;
			arl_blink #(
				.SLOW_CYC (SLOW_HALF_CYC),
				.FAST_CYC (FAST_HALF_CYC)
			) u_blink (
				.clk    (CLK),
				.resetn (RESETN),
				.mode   (blink_mode[2*i+1:2*i]),
				.led    (led)
			);
		end
	endgenerate

	assign NET_ACT_LED = {g_led[2].led, g_led[1].led, g_led[0].led};
	assign LINK_QUALITY_LED = {g_led[4].led, g_led[3].led};

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ABORT_IRQ_N <= 1'b1;
			FAIL_LED <= 1'b1;
			USER_LED <= 3'h0;
			POWER_FAIL_LED <= 1'b0;
			STORAGE_LED0 <= 1'b0;
			STORAGE_LED1 <= 1'b0;
			CPU_READY_LED <= 1'b0;
		end else begin
			ABORT_IRQ_N <= ~abort_pend;
			FAIL_LED <= fail;
			USER_LED <= user_ctrl;
			POWER_FAIL_LED <= psu_fail;
			STORAGE_LED0 <= dual_mode ? sync2[4] : (sync2[4] | sync2[5]);
			STORAGE_LED1 <= dual_mode & sync2[5];
			// Pin carries ready or a trigger event as the processor selects
			CPU_READY_LED <= sync2[6] & ~hr_active;
		end
	end

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			RDATA <= 32'h0;
		end else if (RD) begin
			case (ADDR)
				`ARL_REG_LED_CTRL: RDATA <= {29'h0, user_ctrl};
				`ARL_REG_STATUS: RDATA <= {25'h0, sys_ctrl, psu_fail, dual_mode,
					hr_active, btn, abort_pend, fail};
				default: RDATA <= 32'h0;
			endcase
		end else begin
			RDATA <= 32'h0;
		end
	end
endmodule // arl_top

`default_nettype wire

// ===== hw/arl_map.vh
// Purpose: Constants for the abort/reset button and status LED block.
// Assumes: 20 MHz board clock; register port with 8-bit byte address.
// Notes:   Times are in milliseconds; cycle counts are derived in arl_top.
`ifndef ARL_MAP_VH
`define ARL_MAP_VH

`define ARL_CLK_HZ          20000000
`define ARL_LONG_PRESS_MS   5000
`define ARL_DEBOUNCE_MS     10
`define ARL_HRESET_MS       100
`define ARL_SLOW_HALF_MS    250
`define ARL_FAST_HALF_MS    62
`define ARL_ACT_WINDOW_MS   100
`define ARL_ACT_BUSY_EVENTS 8'h10

`define ARL_REG_LED_CTRL    8'h00
`define ARL_REG_STATUS      8'h04

`define ARL_USER_LED_LSB    0
`define ARL_LED_CTRL_RST    3'h0

`define ARL_ST_FAIL         0
`define ARL_ST_ABORT        1
`define ARL_ST_BUTTON       2
`define ARL_ST_HRESET       3
`define ARL_ST_DUAL_PORT    4
`define ARL_ST_PSU_FAIL     5
`define ARL_ST_SYS_CTRL     6

`define ARL_BLINK_OFF       2'h0
`define ARL_BLINK_SLOW      2'h1
`define ARL_BLINK_FAST      2'h2
`define ARL_BLINK_ON        2'h3

`define ARL_SYNC_W          14
`define ARL_SYNC_RST        14'h0009

`endif

// ===== hw/arl_blink.v
// Purpose: One LED driver with off, slow blink, fast blink and steady on.
// Assumes: mode comes from logic on the same clock.
// Notes:   Phase counter restarts its half period whenever it wraps.
`timescale 1ns/10ps
`default_nettype none
`include "arl_map.vh"

module arl_blink #(
	parameter integer SLOW_CYC = 5000000,
	parameter integer FAST_CYC = 1240000
) (
	input  wire       clk,
	input  wire       resetn,
	input  wire [1:0] mode,
	output reg        led
);
	reg [31:0] cnt;
	reg        phase;
	wire [31:0] half;

	assign half = (mode == `ARL_BLINK_FAST) ? FAST_CYC : SLOW_CYC;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 32'h0;
			phase <= 1'b0;
			led <= 1'b0;
		end else begin
			if (cnt >= half - 32'h1) begin
				cnt <= 32'h0;
				phase <= ~phase;
			end else begin
				cnt <= cnt + 32'h1;
			end
			case (mode)
				`ARL_BLINK_OFF: led <= 1'b0;
				`ARL_BLINK_ON: led <= 1'b1;
				default: led <= phase;
			endcase
		end
	end
endmodule // arl_blink

`default_nettype wire

// ===== tb/arl_properties.sv
// Purpose: Assertions on button, reset and LED outputs of arl_top.
// Assumes: One clock; inputs change just after the rising edge.
// Notes:   Stable windows allow for the two-flop input sync.
`timescale 1ns/10ps
`default_nettype none
module arl_properties #(
	parameter integer LONG_PRESS_CYC = 200,
	parameter integer DEBOUNCE_CYC   = 4
) (
	input wire logic        CLK,
	input wire logic        RESETN,
	input wire logic [7:0]  ADDR,
	input wire logic [31:0] WDATA,
	input wire logic        WR,
	input wire logic        ABORT_RESET_BUTTON_N,
	input wire logic        PSU_FAIL_N,
	input wire logic        ABORT_IRQ_N,
	input wire logic        CPU_RESET_N,
	input wire logic        PLD_RESET_N,
	input wire logic        BACKPLANE_RESET_N,
	input wire logic        BRIDGE_RESET_N,
	input wire logic        FAIL_LED,
	input wire logic [2:0]  USER_LED,
	input wire logic        POWER_FAIL_LED
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	// Counts low samples of the raw pin; any bounce restarts it
	logic [15:0] low_cnt;
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			low_cnt <= 16'h0;
		else if (ABORT_RESET_BUTTON_N)
			low_cnt <= 16'h0;
		else if (low_cnt != 16'hffff)
			low_cnt <= low_cnt + 16'h1;
	end
	user_led_a: assert property (WR && ADDR == 8'h00 |->
		##2 USER_LED == $past(WDATA[2:0], 2)) else $error("user LEDs miss write");
	bp_follow_a: assert property (!BACKPLANE_RESET_N |->
		!CPU_RESET_N && !BRIDGE_RESET_N) else $error("backplane reset alone");
	hreset_len_a: assert property ($fell(CPU_RESET_N) |->
		!PLD_RESET_N ##1 (!CPU_RESET_N) [*8]) else $error("hard reset too short");
	fail_set_a: assert property ($fell(CPU_RESET_N) |-> ##[0:2] FAIL_LED)
		else $error("fail LED not set by reset");
	psu_led_a: assert property (($stable(PSU_FAIL_N)) [*5] |->
		POWER_FAIL_LED == !PSU_FAIL_N) else $error("power fail LED wrong");
	abort_only_a: assert property ($fell(ABORT_IRQ_N) |->
		ABORT_RESET_BUTTON_N && CPU_RESET_N) else $error("abort at wrong time");
	short_press_a: assert property ($rose(ABORT_RESET_BUTTON_N) &&
		low_cnt < LONG_PRESS_CYC |-> CPU_RESET_N [*8]) else $error("short press reset");
	long_press_a: assert property (low_cnt == LONG_PRESS_CYC + DEBOUNCE_CYC |->
		##[1:20] !CPU_RESET_N) else $error("long press gave no reset");
endmodule // arl_properties
bind arl_top arl_properties #(.LONG_PRESS_CYC(LONG_PRESS_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC))
	chk_u (.CLK, .RESETN, .ADDR, .WDATA, .WR, .ABORT_RESET_BUTTON_N, .PSU_FAIL_N,
	.ABORT_IRQ_N, .CPU_RESET_N, .PLD_RESET_N, .BACKPLANE_RESET_N, .BRIDGE_RESET_N,
	.FAIL_LED, .USER_LED, .POWER_FAIL_LED);
`default_nettype wire

// ===== tb/arl_btn_model.sv
// Purpose: Front-panel push button with contact chatter at press.
// Assumes: go is one cycle long; hold is at least eight cycles.
// Notes:   Pull-up keeps the pin high between presses.
`timescale 1ns/10ps
`default_nettype none
module arl_btn_model (
	input  wire logic        clk,
	input  wire logic        go,
	input  wire logic [15:0] hold,
	output wire logic        pin_n
);
	logic [15:0] left = 16'h0;
	logic [15:0] len = 16'h0;
	always @(posedge clk) begin
		if (go) begin
			left <= hold;
			len <= hold;
		end else if (left != 16'h0) begin
			left <= left - 16'h1;
		end
	end
	// Chatter first, so a debouncer that trusts one sample is caught
	assign pin_n = (left == 16'h0) || (left > len - 16'h4 && left[0]);
endmodule // arl_btn_model
`default_nettype wire

// ===== tb/arl_top_bench.sv
// Purpose: Self-checking bench for the button, reset and LED block.
// Assumes: Shortened counts; button model supplies chatter.
// Notes:   Blink modes are judged by edge counts over a window.
`timescale 1ns/10ps
`default_nettype none
`include "arl_map.vh"
module arl_top_bench;
	logic        CLK, RESETN, WR, RD, SYS_CONTROLLER, DUAL_PORT_STORAGE_MODE, PSU_FAIL_N;
	logic        STORAGE0_ACT, STORAGE1_ACT, PROCESSOR_TRIGGER_OUTPUT, go, rd_seen;
	logic [7:0]  ADDR, tick;
	logic [31:0] WDATA, exp_q[$];
	logic [15:0] hold;
	logic [2:0]  NET_ACT;
	logic [1:0]  LINK0_SNR, LINK1_SNR;
	logic [9:0]  cls;
	wire  [31:0] RDATA;
	wire         ABORT_RESET_BUTTON_N, ABORT_IRQ_N, CPU_RESET_N, PCI_RESET_N, PHY_RESET_N;
	wire         SERIAL_RESET_N, FLASH_RESET_N, PLD_RESET_N, BACKPLANE_RESET_N, BRIDGE_RESET_N;
	wire         FAIL_LED, POWER_FAIL_LED, STORAGE_LED0, STORAGE_LED1, CPU_READY_LED;
	wire  [2:0]  USER_LED, NET_ACT_LED;
	wire  [1:0]  LINK_QUALITY_LED;
	wire  [4:0]  leds = {NET_ACT_LED, LINK_QUALITY_LED};
	integer      fails, samples_checked, i, k, n;
	// Shortened timing shared by the instance and the expectations below
	localparam integer LONG_CYC = 200, DEB_CYC = 4, HOLD_CYC = 10;
	localparam integer SLOW_CYC = 16, FAST_CYC = 4, WIN_CYC = 64;
	arl_top #(.LONG_PRESS_CYC(LONG_CYC), .DEBOUNCE_CYC(DEB_CYC), .HRESET_CYC(HOLD_CYC),
		.SLOW_HALF_CYC(SLOW_CYC), .FAST_HALF_CYC(FAST_CYC), .ACT_WINDOW_CYC(WIN_CYC))
		dut_u (.CLK, .RESETN, .ADDR, .WDATA, .WR,
		.RD, .RDATA, .ABORT_RESET_BUTTON_N, .SYS_CONTROLLER, .DUAL_PORT_STORAGE_MODE,
		.PSU_FAIL_N, .STORAGE0_ACT, .STORAGE1_ACT, .PROCESSOR_TRIGGER_OUTPUT, .NET_ACT,
		.LINK0_SNR, .LINK1_SNR, .ABORT_IRQ_N, .CPU_RESET_N, .PCI_RESET_N, .PHY_RESET_N,
		.SERIAL_RESET_N, .FLASH_RESET_N, .PLD_RESET_N, .BACKPLANE_RESET_N, .BRIDGE_RESET_N,
		.FAIL_LED, .USER_LED, .POWER_FAIL_LED, .STORAGE_LED0, .STORAGE_LED1, .CPU_READY_LED,
		.NET_ACT_LED, .LINK_QUALITY_LED);
	arl_btn_model btn_u (.clk(CLK), .go(go), .hold(hold), .pin_n(ABORT_RESET_BUTTON_N));
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	// Link 0 idle, link 1 two events a window, link 2 thirty-two
	always @(posedge CLK) begin
		tick <= tick + 8'h1;
		NET_ACT <= {tick[0], tick[4:0] == 5'h0, 1'b0};
	end
	always @(posedge CLK) rd_seen <= RD;
	always @(negedge CLK) begin
		if (rd_seen)
			cmp(RDATA, exp_q.pop_front());
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input integer c);
		repeat (c) @(posedge CLK);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge CLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CLK);
		RD <= 1'b0;
	endtask
	task automatic do_reset(input logic d);
		@(posedge CLK);
		RESETN <= 1'b0;
		DUAL_PORT_STORAGE_MODE <= d;
		cyc(20);
		cmp({FAIL_LED, ABORT_IRQ_N, CPU_RESET_N, BACKPLANE_RESET_N}, 4'hd);
		RESETN <= 1'b1;
		cyc(30);
		cmp({FAIL_LED, CPU_RESET_N, BACKPLANE_RESET_N, PLD_RESET_N}, 4'hf);
	endtask
	task automatic blink(output logic [9:0] c);
		logic [4:0] prev;
		integer ed[5];
		integer hi[5];
		integer j;
		for (j = 0; j < 5; j++) begin
			ed[j] = 0;
			hi[j] = 0;
		end
		prev = leds;
		repeat (128) begin
			@(negedge CLK);
			for (j = 0; j < 5; j++) begin
				ed[j] += (leds[j] !== prev[j]);
				hi[j] += (leds[j] === 1'b1);
			end
			prev = leds;
		end
		for (j = 0; j < 5; j++)
			c[2*j +: 2] = hi[j] == 0 ? 2'h0 : ed[j] == 0 ? 2'h3 : ed[j] < 16 ? 2'h1 : 2'h2;
	endtask
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		fails = 0;
		samples_checked = 0;
		{WR, RD, go, rd_seen, STORAGE0_ACT, STORAGE1_ACT, PROCESSOR_TRIGGER_OUTPUT} = 7'h0;
		{SYS_CONTROLLER, PSU_FAIL_N, RESETN, DUAL_PORT_STORAGE_MODE} = 4'hc;
		{ADDR, tick, WDATA, hold, NET_ACT, LINK0_SNR, LINK1_SNR} = 0;
		void'($urandom(32'h08bb));
		do_reset(1'b0);
		rd_reg(`ARL_REG_STATUS, 32'h41);
		wr_reg(`ARL_REG_STATUS, 32'h1);
		rd_reg(`ARL_REG_STATUS, 32'h40);
		for (i = 0; i < 6; i++) begin
			n = $urandom;
			wr_reg(`ARL_REG_LED_CTRL, n);
			rd_reg(`ARL_REG_LED_CTRL, n & 7);
			cmp(USER_LED, n[2:0]);
		end
		wr_reg(8'h08, 32'hffffffff);
		rd_reg(8'h08, 32'h0);
		rd_reg(`ARL_REG_LED_CTRL, n & 7);
		PSU_FAIL_N <= 1'b0;
		cyc(6);
		cmp(POWER_FAIL_LED, 1'b1);
		rd_reg(`ARL_REG_STATUS, 32'h60);
		PSU_FAIL_N <= 1'b1;
		cyc(6);
		cmp(POWER_FAIL_LED, 1'b0);
		for (i = 0; i < 4; i++) begin
			{STORAGE0_ACT, STORAGE1_ACT} <= i[1:0];
			PROCESSOR_TRIGGER_OUTPUT <= i[0];
			cyc(8);
			cmp({STORAGE_LED0, STORAGE_LED1, CPU_READY_LED}, {|i[1:0], 1'b0, i[0]});
		end
		for (k = 0; k < 4; k++) begin
			@(posedge CLK);
			LINK0_SNR <= k[1:0];
			LINK1_SNR <= ~k[1:0];
			cyc(140);
			blink(cls);
			cmp(cls, {6'h24, ~k[1:0], k[1:0]});
		end
		@(posedge CLK);
		hold <= 16'd60;
		go <= 1'b1;
		@(posedge CLK);
		go <= 1'b0;
		cyc(100);
		cmp({ABORT_IRQ_N, CPU_RESET_N}, 2'h1);
		rd_reg(`ARL_REG_STATUS, 32'h42);
		wr_reg(`ARL_REG_STATUS, 32'h2);
		cyc(3);
		cmp(ABORT_IRQ_N, 1'b1);
		for (k = 0; k < 2; k++) begin
			SYS_CONTROLLER <= !k[0];
			PROCESSOR_TRIGGER_OUTPUT <= 1'b1;
			hold <= 16'd300;
			go <= 1'b1;
			@(posedge CLK);
			go <= 1'b0;
			n = 0;
			while (CPU_RESET_N !== 1'b0 && n < 400) begin
				@(negedge CLK);
				n++;
			end
			if (n >= 400) begin
				fails++;
				conclude;
			end
			cmp({PCI_RESET_N, PHY_RESET_N, SERIAL_RESET_N, FLASH_RESET_N, PLD_RESET_N,
				BACKPLANE_RESET_N, BRIDGE_RESET_N, CPU_READY_LED}, {5'h0, {2{k[0]}}, 1'b0});
			n = 0;
			while (CPU_RESET_N === 1'b0 && n < 400) begin
				@(negedge CLK);
				n++;
			end
			cmp(n, HOLD_CYC);
			cyc(150);
			cmp({FAIL_LED, ABORT_IRQ_N}, 2'h3);
			wr_reg(`ARL_REG_STATUS, 32'h1);
		end
		do_reset(1'b1);
		rd_reg(`ARL_REG_STATUS, 32'h11);
		for (i = 0; i < 4; i++) begin
			{STORAGE0_ACT, STORAGE1_ACT} <= i[1:0];
			cyc(8);
			cmp({STORAGE_LED0, STORAGE_LED1}, i[1:0]);
		end
		cyc(4);
		conclude;
	end
endmodule // arl_top_bench
`default_nettype wire
